// ### src/pattern_next_data_stage.sv
// The APB slave port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none

module pattern_next_data_stage
  import pattern_stage_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              resetn,
  input  wire logic              clk_en,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic [3:0]        cmp_match_a,
  input  wire logic [3:0]        cmp_match_b,
  output logic      [7:0]        port_a_pins,
  output logic      [7:0]        port_b_pins,
  output logic      [7:0]        port_a_oe,
  output logic      [7:0]        port_b_oe
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  logic [7:0]  upper_byte_output_enable_q;
  logic [7:0]  lower_byte_output_enable_q;
  logic [7:0]  group_trigger_select_q;
  logic [3:0]  group_nonoverlap_enable_q;
  logic [15:0] staged_q;
  logic [15:0] pattern_q;
  logic [31:0] prdata_q;
  logic        err_q;
  logic [15:0] enables;
  logic        upper_shared;
  logic        lower_shared;
  logic [3:0]  trig_a;
  logic [3:0]  trig_b;
  logic        setup;
  logic        wr;
  logic [7:0]  wbyte;
  logic [7:0]  rbyte;
  logic        mapped;

  assign enables = {upper_byte_output_enable_q, lower_byte_output_enable_q};
  assign setup   = clk_en && psel && !penable;
  assign wr      = clk_en && psel && penable && pwrite;
  assign wbyte   = pwdata[7:0];

  // ---------------------------------------------------------------
  // Trigger selection and layout
  // ---------------------------------------------------------------
  always_comb begin
    for (int g = 0; g < GROUPS; g++) begin
      trig_a[g] = cmp_match_a[group_trigger_select_q[g*SEL_BITS +: SEL_BITS]];
      trig_b[g] = cmp_match_b[group_trigger_select_q[g*SEL_BITS +: SEL_BITS]];
    end
  end

  assign upper_shared = group_trigger_select_q[7:6] == group_trigger_select_q[5:4];
  assign lower_shared = group_trigger_select_q[3:2] == group_trigger_select_q[1:0];

  // ---------------------------------------------------------------
  // Read decode
  // ---------------------------------------------------------------
  always_comb begin
    rbyte  = 8'h00;
    mapped = 1'b1;
    unique case (paddr)
      ADDR_NONOVERLAP:  rbyte = {NONOVERLAP_PAD, group_nonoverlap_enable_q};
      ADDR_TRIG_SELECT: rbyte = group_trigger_select_q;
      ADDR_UPPER_EN:    rbyte = upper_byte_output_enable_q;
      ADDR_LOWER_EN:    rbyte = lower_byte_output_enable_q;
      ADDR_UPPER_PRI: begin
        if (upper_shared) begin
          rbyte = staged_q[15:8];
        end else begin
          rbyte = {staged_q[15:12], RESERVED_NIBBLE};
        end
      end
      ADDR_UPPER_SEC: begin
        if (upper_shared) begin
          rbyte = RESERVED_BYTE;
        end else begin
          rbyte = {RESERVED_NIBBLE, staged_q[11:8]};
        end
      end
      ADDR_LOWER_PRI: begin
        if (lower_shared) begin
          rbyte = staged_q[7:0];
        end else begin
          rbyte = {staged_q[7:4], RESERVED_NIBBLE};
        end
      end
      ADDR_LOWER_SEC: begin
        if (lower_shared) begin
          rbyte = RESERVED_BYTE;
        end else begin
          rbyte = {RESERVED_NIBBLE, staged_q[3:0]};
        end
      end
      ADDR_PIN_STATE:   rbyte = pattern_q[7:0];
      default:          mapped = 1'b0;
    endcase
  end

  // ---------------------------------------------------------------
  // APB answer
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      prdata_q <= 32'h0000_0000;
      err_q    <= 1'b0;
    end else if (setup) begin
      prdata_q <= (paddr == ADDR_PIN_STATE) ? {16'h0000, pattern_q} : {24'h00_0000, rbyte};
      err_q    <= !mapped;
    end
  end

  assign prdata  = prdata_q;
  assign pready  = clk_en;
  assign pslverr = psel && penable && err_q;

  // ---------------------------------------------------------------
  // Control registers
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      upper_byte_output_enable_q <= RST_ENABLE;
      lower_byte_output_enable_q <= RST_ENABLE;
      group_trigger_select_q     <= RST_TRIG_SELECT;
      group_nonoverlap_enable_q  <= RST_NONOVERLAP;
    end else if (wr) begin
      if (paddr == ADDR_UPPER_EN) begin
        upper_byte_output_enable_q <= wbyte;
      end
      if (paddr == ADDR_LOWER_EN) begin
        lower_byte_output_enable_q <= wbyte;
      end
      if (paddr == ADDR_TRIG_SELECT) begin
        group_trigger_select_q <= wbyte;
      end
      if (paddr == ADDR_NONOVERLAP) begin
        group_nonoverlap_enable_q <= wbyte[3:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // Staging registers
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      staged_q <= RST_STAGED;
    end else if (wr) begin
      unique case (paddr)
        ADDR_UPPER_PRI: begin
          staged_q[15:12] <= wbyte[7:4];
          if (upper_shared) begin
            staged_q[11:8] <= wbyte[3:0];
          end
        end
        ADDR_UPPER_SEC: begin
          if (!upper_shared) begin
            staged_q[11:8] <= wbyte[3:0];
          end
        end
        ADDR_LOWER_PRI: begin
          staged_q[7:4] <= wbyte[7:4];
          if (lower_shared) begin
            staged_q[3:0] <= wbyte[3:0];
          end
        end
        ADDR_LOWER_SEC: begin
          if (!lower_shared) begin
            staged_q[3:0] <= wbyte[3:0];
          end
        end
        default: begin
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Pattern transfer
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      pattern_q <= RST_PATTERN;
    end else if (clk_en) begin
      for (int i = 0; i < 16; i++) begin
        if (enables[i]) begin
          if (trig_a[i/GROUP_BITS]) begin
            pattern_q[i] <= staged_q[i];
          end else if (group_nonoverlap_enable_q[i/GROUP_BITS] && trig_b[i/GROUP_BITS]) begin
            pattern_q[i] <= pattern_q[i] & staged_q[i];
          end
        end
      end
    end
  end

  assign port_a_pins = pattern_q[7:0];
  assign port_b_pins = {pattern_q[15], 1'b0, pattern_q[13:8]};
  assign port_a_oe   = lower_byte_output_enable_q;
  assign port_b_oe   = {upper_byte_output_enable_q[7], 1'b0, upper_byte_output_enable_q[5:0]};

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  upper_gate_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (upper_byte_output_enable_q == 8'h00) |=> $stable(pattern_q[15:8]))
    else $error("Upper pattern changed with all enables off.");

  lower_gate_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (lower_byte_output_enable_q == 8'h00) |=> $stable(pattern_q[7:0]))
    else $error("Lower pattern changed with all enables off.");

  upper_shared_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (setup && upper_shared && paddr == ADDR_UPPER_SEC) ##1 penable |-> prdata == 32'h0000_00FF)
    else $error("Shared upper secondary did not read all ones.");

  upper_split_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (setup && !upper_shared && paddr == ADDR_UPPER_PRI) |=> prdata[3:0] == 4'hF)
    else $error("Split upper primary low nibble not ones.");

  lower_shared_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (setup && lower_shared && paddr == ADDR_LOWER_SEC) |=> prdata[7:0] == 8'hFF)
    else $error("Shared lower secondary did not read all ones.");

  lower_split_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (setup && !lower_shared && paddr == ADDR_LOWER_PRI) |=> prdata[3:0] == 4'hF)
    else $error("Split lower primary low nibble not ones.");

  lower_second_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (setup && !lower_shared && paddr == ADDR_LOWER_SEC) |=> prdata[7:4] == 4'hF)
    else $error("Split lower secondary high nibble not ones.");

  no_pin_a: assert property (@(posedge core_clk) disable iff (!resetn)
    port_b_pins[NO_PIN_PORTB] == 1'b0 && port_b_oe[NO_PIN_PORTB] == 1'b0)
    else $error("Pattern bit without a pin was driven.");

  group_copy_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (clk_en && lower_byte_output_enable_q[0] && cmp_match_a[group_trigger_select_q[1:0]])
      |=> port_a_pins[0] == $past(staged_q[0]))
    else $error("Group 0 did not take staged bit on its trigger.");

  nonoverlap_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (clk_en && !trig_a[0] && (!group_nonoverlap_enable_q[0] || !trig_b[0]))
      |=> $stable(pattern_q[3:0]))
    else $error("Group 0 changed without its compare event.");

  upper_copy_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (clk_en && upper_byte_output_enable_q[7] && trig_a[3])
      |=> pattern_q[15] == $past(staged_q[15]))
    else $error("Enabled upper bit did not take its staged value.");

  upper_block_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (upper_byte_output_enable_q[4] == 1'b0)
      |=> $stable(pattern_q[12]))
    else $error("Disabled upper bit changed.");

  lower_copy_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (clk_en && lower_byte_output_enable_q[4] && trig_a[1])
      |=> pattern_q[4] == $past(staged_q[4]))
    else $error("Enabled lower bit did not take its staged value.");

  lower_block_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (lower_byte_output_enable_q[7] == 1'b0)
      |=> $stable(pattern_q[7]))
    else $error("Disabled lower bit changed.");

  upper_write_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (wr && upper_shared && paddr == ADDR_UPPER_PRI)
      |=> staged_q[15:8] == $past(wbyte))
    else $error("Shared upper write did not fill the whole byte.");

  upper_ignore_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (wr && upper_shared && paddr == ADDR_UPPER_SEC)
      |=> $stable(staged_q[11:8]))
    else $error("Shared upper secondary write changed staged data.");

  upper_keep_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (wr && !upper_shared && paddr == ADDR_UPPER_PRI)
      |=> $stable(staged_q[11:8]))
    else $error("Split upper primary write touched group 2.");

  upper_high_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (setup && !upper_shared && paddr == ADDR_UPPER_PRI)
      |=> prdata[7:4] == $past(staged_q[15:12]))
    else $error("Split upper primary did not read group 3.");

  upper_second_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (setup && !upper_shared && paddr == ADDR_UPPER_SEC)
      |=> prdata[7:4] == 4'hF)
    else $error("Split upper secondary high nibble not ones.");

  lower_write_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (wr && lower_shared && paddr == ADDR_LOWER_PRI)
      |=> staged_q[7:0] == $past(wbyte))
    else $error("Shared lower write did not fill the whole byte.");

  lower_keep_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (wr && !lower_shared && paddr == ADDR_LOWER_PRI)
      |=> $stable(staged_q[3:0]))
    else $error("Split lower primary write touched group 0.");

  group_zero_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (wr && !lower_shared && paddr == ADDR_LOWER_SEC)
      |=> staged_q[3:0] == $past(wbyte[3:0]))
    else $error("Split lower secondary write did not fill group 0.");

  hidden_bit_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (clk_en && upper_byte_output_enable_q[6] && trig_a[3])
      |=> pattern_q[NO_PIN_BIT] == $past(staged_q[NO_PIN_BIT]))
    else $error("Pattern bit without a pin was not updated.");

  upper_select_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (clk_en && upper_byte_output_enable_q[0] && cmp_match_a[group_trigger_select_q[5:4]])
      |=> pattern_q[8] == $past(staged_q[8]))
    else $error("Group 2 did not take staged bit on its trigger.");

  overlap_fall_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (clk_en && lower_byte_output_enable_q[0] && group_nonoverlap_enable_q[0]
      && !trig_a[0] && trig_b[0])
      |=> !$rose(pattern_q[0]))
    else $error("Non-overlap group rose at compare B.");

  freeze_state_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (!clk_en)
      |=> $stable(pattern_q) && $stable(staged_q))
    else $error("State changed while the clock enable was low.");

  layout_pick_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (setup && paddr == ADDR_UPPER_PRI
      && group_trigger_select_q[7:6] == group_trigger_select_q[5:4])
      |=> prdata[3:0] == $past(staged_q[11:8]))
    else $error("Equal upper codes did not give the shared layout.");

endmodule

`default_nettype wire

// ### src/pattern_stage_pkg.sv
package pattern_stage_pkg;

  // ---------------------------------------------------------------
  // Register indices and byte addresses
  // ---------------------------------------------------------------
  localparam int unsigned ADDR_W = 18;

  localparam logic [15:0] IDX_NONOVERLAP   = 16'h00A0;
  localparam logic [15:0] IDX_TRIG_SELECT  = 16'h00A1;
  localparam logic [15:0] IDX_UPPER_EN     = 16'h00A2;
  localparam logic [15:0] IDX_LOWER_EN     = 16'h00A3;
  localparam logic [15:0] IDX_UPPER_PRI    = 16'hFFA4;
  localparam logic [15:0] IDX_LOWER_PRI    = 16'hFFA5;
  localparam logic [15:0] IDX_UPPER_SEC    = 16'hFFA6;
  localparam logic [15:0] IDX_LOWER_SEC    = 16'hFFA7;
  localparam logic [15:0] IDX_PIN_STATE    = 16'h009F;

  localparam logic [ADDR_W-1:0] ADDR_NONOVERLAP  = {IDX_NONOVERLAP, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_TRIG_SELECT = {IDX_TRIG_SELECT, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_UPPER_EN    = {IDX_UPPER_EN, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_LOWER_EN    = {IDX_LOWER_EN, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_UPPER_PRI   = {IDX_UPPER_PRI, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_LOWER_PRI   = {IDX_LOWER_PRI, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_UPPER_SEC   = {IDX_UPPER_SEC, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_LOWER_SEC   = {IDX_LOWER_SEC, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_PIN_STATE   = {IDX_PIN_STATE, 2'b00};

  // ---------------------------------------------------------------
  // Reset values and fixed read patterns
  // ---------------------------------------------------------------
  localparam logic [7:0]  RST_ENABLE      = 8'h00;
  localparam logic [7:0]  RST_TRIG_SELECT = 8'hFF;
  localparam logic [3:0]  RST_NONOVERLAP  = 4'h0;
  localparam logic [15:0] RST_STAGED      = 16'h0000;
  localparam logic [15:0] RST_PATTERN     = 16'h0000;
  localparam logic [7:0]  RESERVED_BYTE   = 8'hFF;
  localparam logic [3:0]  RESERVED_NIBBLE = 4'hF;
  localparam logic [3:0]  NONOVERLAP_PAD  = 4'hF;

  // ---------------------------------------------------------------
  // Field layout
  // ---------------------------------------------------------------
  localparam int unsigned GROUPS       = 4;
  localparam int unsigned GROUP_BITS   = 4;
  localparam int unsigned SEL_BITS     = 2;
  localparam int unsigned CHANNELS     = 4;
  localparam int unsigned NO_PIN_BIT   = 14;
  localparam int unsigned NO_PIN_PORTB = 6;

endpackage

// ### testbench/timer_match_source.sv
`timescale 1ns/1ps
`default_nettype none

module timer_match_source (
  input  wire logic       core_clk,
  output logic      [3:0] cmp_match_a,
  output logic      [3:0] cmp_match_b
);
  // ---------------------------------------------------------------
  // Timer compare-match events
  // ---------------------------------------------------------------
  initial begin
    cmp_match_a = 4'h0;
    cmp_match_b = 4'h0;
  end

  // Raises compare A or B of one channel for exactly one cycle.
  task automatic fire(input logic [1:0] ch, input logic use_b);
    @(posedge core_clk);
    if (use_b) begin
      cmp_match_b[ch] <= 1'b1;
    end else begin
      cmp_match_a[ch] <= 1'b1;
    end
    @(posedge core_clk);
    cmp_match_a <= 4'h0;
    cmp_match_b <= 4'h0;
  endtask
endmodule

`default_nettype wire

// ### testbench/pattern_next_data_stage_bench.sv
`timescale 1ns/1ps
`default_nettype none

module pattern_next_data_stage_bench
  import pattern_stage_pkg::*;
;
  logic              core_clk, resetn, clk_en, psel, penable, pwrite;
  logic [ADDR_W-1:0] paddr;
  logic [31:0]       pwdata, prdata, rd;
  logic              pready, pslverr, er;
  logic [3:0]        cmp_a, cmp_b;
  logic [7:0]        pa, pb, pa_oe, pb_oe;
  int                err_total, cmp_count;
  logic [15:0]       per_ch [4] = '{16'h350C, 16'h3C0C, 16'h3C9C, 16'h3C97};

  pattern_next_data_stage dut (.core_clk(core_clk), .resetn(resetn), .clk_en(clk_en),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .cmp_match_a(cmp_a),
    .cmp_match_b(cmp_b), .port_a_pins(pa), .port_b_pins(pb), .port_a_oe(pa_oe),
    .port_b_oe(pb_oe));

  timer_match_source tm (.core_clk(core_clk), .cmp_match_a(cmp_a), .cmp_match_b(cmp_b));

  always #2 core_clk = ~core_clk;

  // ---------------------------------------------------------------
  // Access and compare tasks
  // ---------------------------------------------------------------
  task automatic report_and_stop;
    if (err_total == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= {24'h000000, d};
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      err_total++;
      report_and_stop();
    end
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdchk(input string nm, input logic [ADDR_W-1:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    chk(nm, {8'h00, e}, {8'h00, rd[7:0]});
  endtask

  task automatic trig(input logic [1:0] ch, input logic use_b, input logic [15:0] e);
    tm.fire(ch, use_b);
    @(posedge core_clk);
    chk("pins", e, {pb, pa});
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    resetn = 1'b0;
    clk_en = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    err_total = 0;
    cmp_count = 0;
    repeat (8) @(posedge core_clk);
    resetn <= 1'b1;
    rdchk("upper_en", ADDR_UPPER_EN, 8'h00);
    rdchk("lower_en", ADDR_LOWER_EN, 8'h00);
    rdchk("lower_sec", ADDR_LOWER_SEC, 8'hFF);
    wr(ADDR_UPPER_PRI, 8'hE5);
    wr(ADDR_LOWER_PRI, 8'h3C);
    wr(ADDR_UPPER_SEC, 8'h00);
    rdchk("upper_pri", ADDR_UPPER_PRI, 8'hE5);
    rdchk("upper_sec", ADDR_UPPER_SEC, 8'hFF);
    rdchk("lower_pri", ADDR_LOWER_PRI, 8'h3C);
    trig(2'd3, 1'b0, 16'h0000);
    wr(ADDR_UPPER_EN, 8'hFF);
    wr(ADDR_LOWER_EN, 8'h0F);
    @(posedge core_clk);
    chk("oe", 16'hBF0F, {pb_oe, pa_oe});
    trig(2'd3, 1'b0, 16'hA50C);
    apb(1'b0, ADDR_PIN_STATE, 8'h00);
    chk("pattern", 16'hE50C, rd[15:0]);
    wr(ADDR_LOWER_EN, 8'hFF);
    wr(ADDR_TRIG_SELECT, 8'h1B);
    rdchk("upper_pri", ADDR_UPPER_PRI, 8'hEF);
    rdchk("upper_sec", ADDR_UPPER_SEC, 8'hF5);
    rdchk("lower_pri", ADDR_LOWER_PRI, 8'h3F);
    rdchk("lower_sec", ADDR_LOWER_SEC, 8'hFC);
    wr(ADDR_UPPER_PRI, 8'h3A);
    wr(ADDR_UPPER_SEC, 8'h6C);
    wr(ADDR_LOWER_PRI, 8'h9A);
    wr(ADDR_LOWER_SEC, 8'h17);
    rdchk("upper_pri", ADDR_UPPER_PRI, 8'h3F);
    rdchk("upper_sec", ADDR_UPPER_SEC, 8'hFC);
    rdchk("lower_pri", ADDR_LOWER_PRI, 8'h9F);
    rdchk("lower_sec", ADDR_LOWER_SEC, 8'hF7);
    for (int ch = 0; ch < 4; ch++) begin
      trig(ch[1:0], 1'b0, per_ch[ch]);
    end
    wr(ADDR_NONOVERLAP, 8'h01);
    wr(ADDR_LOWER_SEC, 8'h10);
    trig(2'd3, 1'b1, 16'h3C90);
    wr(ADDR_LOWER_SEC, 8'h15);
    trig(2'd3, 1'b1, 16'h3C90);
    trig(2'd3, 1'b0, 16'h3C95);
    wr(ADDR_LOWER_PRI, 8'h0A);
    trig(2'd2, 1'b1, 16'h3C95);
    wr(ADDR_LOWER_SEC, 8'h1A);
    clk_en <= 1'b0;
    trig(2'd3, 1'b0, 16'h3C95);
    clk_en <= 1'b1;
    trig(2'd3, 1'b0, 16'h3C9A);
    apb(1'b0, 18'h00010, 8'h00);
    chk("slverr", 16'h0001, {15'h0000, er});
    report_and_stop();
  end
endmodule

`default_nettype wire
